/* File: core/device_config_space_regs.sv */
// Purpose: architected configuration registers and option rom window of a plug-in device
// Assumes: bus requests and slot enable come from logic on core_clk_i
// Notes: config access answers one cycle after it is taken, rom reads two, refused or skipped rom accesses one
`timescale 1ns/1ps
module device_config_space_regs
  import cfg_space_pkg::*;
#(
  parameter char_cfg_t CHAR_CFG = '{dev_class: 4'h3, unit_alloc: 2'h3, mem1: 4'h1,
                                    mem2: 4'h2, rom_ind: 2'h3, incr: 3'h0},
  parameter logic WIDE_VARIANT = 1'b0,
  parameter logic DEFER_IDENTITY = 1'b0,
  parameter logic THIRD_PARTY = 1'b1,           // arbitrary value
  parameter logic [15:0] DEVICE_TYPE = 16'h0040, // arbitrary value
  parameter logic [7:0] DEVICE_NUMBER = 8'h5A   // arbitrary value
) (
  input wire logic core_clk_i,        // system bus clock
  input wire logic reset_i,           // async reset, high
  input wire logic clk_en_i,          // freezes all state when low
  input wire logic slot_en_i,         // slot enable for this device
  input wire logic req_valid_i,       // bus request present
  input wire bus_req_t req_i,         // bus request fields
  input wire logic [31:0] rom_data_i, // rom word, sampled while rom_rd_o stands
  output logic busy_o,                // rom read in flight, no request taken
  output logic ack_o,                 // answer pulse
  output logic err_o,                 // refused access, with ack_o
  output logic [63:0] rdata_o,        // read data
  output logic [1:0] mem_hit_o,       // memory region hit per request
  output logic rom_rd_o,              // rom read strobe
  output logic [ROM_AW-3:0] rom_addr_o // rom content word address
);
  typedef enum logic {ST_IDLE, ST_ROM} state_t;

  // mask of base bits kept for an allocation code
  function automatic logic [WIDE_BASE_W-1:0] base_mask(input logic [3:0] code, input logic wide);
    logic [WIDE_BASE_W-1:0] m;
    m = '0;
    if (code != 4'h0) begin
      m = {WIDE_BASE_W{1'b1}} << (code - 4'h1);
    end
    if (!wide) begin
      m = m & {{(WIDE_BASE_W-NARROW_BASE_W){1'b0}}, {NARROW_BASE_W{1'b1}}};
    end
    return m;
  endfunction

  // number of identifier registers for an allocation code
  function automatic logic [2:0] unit_count(input logic [1:0] code);
    logic [2:0] n;
    n = 3'h0;
    unique case (code)
      2'h0: n = 3'h0;
      2'h1: n = 3'h1;
      2'h2: n = 3'h2;
      2'h3: n = 3'h4;
    endcase
    return n;
  endfunction

  // big-endian byte lane of a rom word
  function automatic logic [7:0] rom_byte(input logic [31:0] w, input logic [1:0] lane);
    logic [7:0] b;
    b = 8'h00;
    unique case (lane)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      2'h3: b = w[7:0];
    endcase
    return b;
  endfunction

  state_t state_reg;
  logic [UNIT_W-1:0] unit_id_reg [4];
  logic [WIDE_BASE_W-1:0] base_reg [2];
  logic [1:0] lane_reg;
  logic word_reg;

  // characteristics and identity words are constants of the design
  wire logic [31:0] char_word = ({28'h0, CHAR_CFG.dev_class} << CH_CLASS_LSB) |
                                ({30'h0, CHAR_CFG.unit_alloc} << CH_ALLOC_LSB) |
                                ({28'h0, CHAR_CFG.mem1} << CH_MEM1_LSB) |
                                ({28'h0, CHAR_CFG.mem2} << CH_MEM2_LSB) |
                                ({30'h0, CHAR_CFG.rom_ind} << CH_ROM_LSB) |
                                ({29'h0, CHAR_CFG.incr} << CH_INC_LSB);
  wire logic [23:0] ident_hi = DEFER_IDENTITY ? 24'h0 : {DEVICE_TYPE, DEVICE_NUMBER};
  wire logic [31:0] ident_word = {THIRD_PARTY, ID_RSVD_VALUE, ident_hi};

  // spacing from the increment field
  wire logic [2:0] delta_shift = (CHAR_CFG.incr == INC_8) ? 3'(DELTA_SHIFT_MIN + 1) :
                                 3'(DELTA_SHIFT_MIN);
  wire logic [63:0] delta_mask = (64'h1 << delta_shift) - 64'h1;

  // request acceptance
  // busy_o and ST_ROM always move together, so the state test is the busy test;
  // a request that arrives during a rom read waits with its valid held
  wire logic take = clk_en_i && req_valid_i && (state_reg == ST_IDLE);

  // configuration window decode
  wire logic [63:0] cfg_off = req_i.addr - CFG_BASE;
  wire logic in_cfg = (req_i.addr >= CFG_BASE) && (cfg_off < CFG_SPAN);
  wire logic cfg_aligned = (cfg_off & delta_mask) == 64'h0;
  wire logic [63:0] cfg_idx64 = cfg_off >> delta_shift;
  wire logic [4:0] cfg_idx = cfg_idx64[4:0];
  wire logic [4:0] unit_rel = cfg_idx - IDX_UNIT_FIRST;
  wire logic is_unit = cfg_aligned && (cfg_idx >= IDX_UNIT_FIRST) &&
                       ({2'h0, unit_rel} < {4'h0, unit_count(CHAR_CFG.unit_alloc)});
  wire logic [4:0] idx_base2 = WIDE_VARIANT ? IDX_BASE2_WIDE : IDX_BASE2_NARROW;
  wire logic is_base1 = cfg_aligned && (cfg_idx == IDX_BASE1) && (CHAR_CFG.mem1 != 4'h0);
  wire logic is_base2 = cfg_aligned && (cfg_idx == idx_base2) && (CHAR_CFG.mem2 != 4'h0);
  wire logic [WIDE_BASE_W-1:0] mask1 = base_mask(CHAR_CFG.mem1, WIDE_VARIANT);
  wire logic [WIDE_BASE_W-1:0] mask2 = base_mask(CHAR_CFG.mem2, WIDE_VARIANT);
  wire logic [WIDE_BASE_W-1:0] wr_base = WIDE_VARIANT ? req_i.wdata[63:BASE_LSB] :
    {{(WIDE_BASE_W-NARROW_BASE_W){1'b0}}, req_i.wdata[31:BASE_LSB]};

  // rom window decode
  // spacing and skip rules act on the window offset only; the window base is
  // aligned far beyond any spacing, so no carry from them reaches the base
  wire logic [63:0] rom_off64 = req_i.addr - ROM_BASE;
  wire logic [ROM_AW-1:0] rom_off = rom_off64[ROM_AW-1:0];
  wire logic rom_present = (CHAR_CFG.dev_class == CLASS_IO) && (CHAR_CFG.rom_ind != ROM_NONE);
  wire logic in_rom_span = (req_i.addr >= ROM_BASE) && (req_i.addr <= ROM_LAST);
  wire logic in_rom = in_rom_span && rom_present && slot_en_i;
  wire logic rom_skip = (CHAR_CFG.incr == INC_8) && rom_off[SKIP_BIT];
  wire logic [ROM_AW-1:0] content_off = (CHAR_CFG.incr == INC_8) ?
    {1'b0, rom_off[ROM_AW-1:SKIP_BIT+1], rom_off[SKIP_BIT-1:0]} : rom_off;
  wire logic word_ok = (CHAR_CFG.rom_ind == ROM_WORD) && (rom_off[1:0] == 2'h0);
  wire logic rom_size_ok = (req_i.size == SZ_BYTE) || ((req_i.size == SZ_WORD) && word_ok);

  // memory region decode on the stored bases
  wire logic [WIDE_BASE_W-1:0] req_page = WIDE_VARIANT ? req_i.addr[63:BASE_LSB] :
    {{(WIDE_BASE_W-NARROW_BASE_W){1'b0}}, req_i.addr[31:BASE_LSB]};
  wire logic hit1 = (CHAR_CFG.mem1 != 4'h0) && ((req_page & mask1) == base_reg[0]);
  wire logic hit2 = (CHAR_CFG.mem2 != 4'h0) && ((req_page & mask2) == base_reg[1]);
  // narrow bases sit in the top of a word, wide ones fill the double word
  wire logic [63:0] base_rd1 = WIDE_VARIANT ? {base_reg[0], 20'h0} :
                                {32'h0, base_reg[0][NARROW_BASE_W-1:0], 20'h0};
  wire logic [63:0] base_rd2 = WIDE_VARIANT ? {base_reg[1], 20'h0} :
                                {32'h0, base_reg[1][NARROW_BASE_W-1:0], 20'h0};

  // configuration read mux; anything else reads zero
  logic [63:0] cfg_rdata;
  always_comb begin
    cfg_rdata = 64'h0;
    if (cfg_aligned && cfg_idx == IDX_CHAR) begin
      cfg_rdata = {32'h0, char_word};
    end else if (cfg_aligned && cfg_idx == IDX_IDENT) begin
      cfg_rdata = {32'h0, ident_word};
    end else if (is_unit) begin
      cfg_rdata = {39'h0, unit_id_reg[unit_rel[1:0]], 16'h0};
    end else if (is_base1) begin
      cfg_rdata = base_rd1;
    end else if (is_base2) begin
      cfg_rdata = base_rd2;
    end
  end

  // identifier registers, written only in the implemented field
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int k = 0; k < 4; k++) begin
        unit_id_reg[k] <= '0;
      end
    end else if (take && in_cfg && req_i.write && is_unit) begin
      unit_id_reg[unit_rel[1:0]] <= req_i.wdata[UNIT_LSB+UNIT_W-1:UNIT_LSB];
    end
  end

  // base registers keep only bits that size and alignment need
  // software is trusted to align the base; low bits it writes are dropped,
  // not rounded, so a misaligned base lands on the region below it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      base_reg[0] <= '0;
      base_reg[1] <= '0;
    end else if (take && in_cfg && req_i.write) begin
      if (is_base1) begin
        base_reg[0] <= wr_base & mask1;
      end
      if (is_base2) begin
        base_reg[1] <= wr_base & mask2;
      end
    end
  end

  // answer sequencing; a rom read holds the bus one extra cycle for the rom
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      busy_o <= 1'b0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 64'h0;
      rom_rd_o <= 1'b0;
      rom_addr_o <= '0;
      lane_reg <= 2'h0;
      word_reg <= 1'b0;
    end else if (clk_en_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rom_rd_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (take && in_cfg) begin
            ack_o <= 1'b1;
            rdata_o <= req_i.write ? 64'h0 : cfg_rdata;
          end else if (take && in_rom) begin
            ack_o <= 1'b1;
            rdata_o <= 64'h0;
            if (req_i.write || !rom_size_ok) begin
              err_o <= 1'b1;
            end else if (!rom_skip) begin
              ack_o <= 1'b0;
              rom_rd_o <= 1'b1;
              rom_addr_o <= content_off[ROM_AW-1:2];
              lane_reg <= content_off[1:0];
              word_reg <= (req_i.size == SZ_WORD);
              busy_o <= 1'b1;
              state_reg <= ST_ROM;
            end
          end
        end
        ST_ROM: begin
          ack_o <= 1'b1;
          rdata_o <= word_reg ? {32'h0, rom_data_i} : {56'h0, rom_byte(rom_data_i, lane_reg)};
          busy_o <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // region hits, refreshed on every taken request
  // the flags only observe the request; the memory space path that acts
  // on them lies outside this block, so no answer is given here
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mem_hit_o <= 2'h0;
    end else if (clk_en_i) begin
      mem_hit_o <= take ? {hit2, hit1} : 2'h0;
    end
  end

  // checks
  // all checks stop while reset is high; the clock enable is not part of the
  // disable, so properties that may span a frozen cycle say so themselves
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  wire logic rd_ident = take && in_cfg && !req_i.write && cfg_aligned && cfg_idx == IDX_IDENT;
  wire logic rd_unit = take && in_cfg && !req_i.write && is_unit;
  wire logic rd_base1 = take && in_cfg && !req_i.write && is_base1;
  wire logic rom_good = take && in_rom && !req_i.write && rom_size_ok && !rom_skip;

  a_ident_value: assert property (rd_ident |=> ack_o && rdata_o == {32'h0, ident_word})
    else $error("identity word read wrong");
  a_ident_reserved: assert property (rd_ident |=> rdata_o[ID_RSVD_LSB+6:ID_RSVD_LSB] == 7'h0 &&
                                     rdata_o[ID_MAKER_BIT] == THIRD_PARTY)
    else $error("identity reserved bits not zero");
  a_ident_defer: assert property (rd_ident && DEFER_IDENTITY |=> rdata_o[23:0] == 24'h0)
    else $error("deferred identity not zero");
  a_unit_field: assert property (rd_unit |=> ack_o && rdata_o[15:0] == 16'h0 &&
                                 rdata_o[63:UNIT_LSB+UNIT_W] == '0)
    else $error("identifier read has stray bits");
  a_unit_write: assert property (take && in_cfg && req_i.write && is_unit |=>
                                 unit_id_reg[$past(unit_rel[1:0])] ==
                                 $past(req_i.wdata[UNIT_LSB+UNIT_W-1:UNIT_LSB]))
    else $error("identifier not written back");
  a_base_masked: assert property (rd_base1 |=> (rdata_o[63:BASE_LSB] & ~mask1) == '0 &&
                                  rdata_o[BASE_LSB-1:0] == '0)
    else $error("base register keeps unneeded bits");
  a_unit_absent: assert property (take && in_cfg && !req_i.write && cfg_aligned &&
                                  cfg_idx >= IDX_UNIT_FIRST && cfg_idx < IDX_BASE1 && !is_unit
                                  |=> rdata_o == 64'h0)
    else $error("absent identifier register reads non-zero");
  a_rom_gated: assert property (take && in_rom_span && !slot_en_i && !in_cfg
                                |=> !ack_o && !rom_rd_o)
    else $error("rom answered without slot enable");
  a_rom_word_ref: assert property (take && in_rom && req_i.size == SZ_WORD &&
                                   CHAR_CFG.rom_ind == ROM_BYTE |=> ack_o && err_o)
    else $error("word access to byte rom not refused");
  a_rom_read_seq: assert property (rom_good |=> (rom_rd_o && !ack_o && busy_o)
                                   ##1 (ack_o || busy_o))
    else $error("rom read strobe missing");
  a_rom_skip: assert property (take && in_rom && !req_i.write && rom_size_ok && rom_skip
                               |=> ack_o && rdata_o == 64'h0 && !rom_rd_o)
    else $error("skipped rom word not empty");
  a_mem_absent: assert property (CHAR_CFG.mem2 == 4'h0 |-> !mem_hit_o[1])
    else $error("absent region decoded");

  // every taken config access is answered next cycle and never refused
  a_cfg_answer: assert property (take && in_cfg |=> ack_o && !err_o)
    else $error("config access not answered");

  // a misaligned offset matches no register and reads as zero
  a_misaligned_zero: assert property (take && in_cfg && !req_i.write && !cfg_aligned |=> rdata_o == 64'h0)
    else $error("misaligned config read not zero");

  // the class field of the characteristics word is the configured one
  a_char_class: assert property (take && in_cfg && !req_i.write && cfg_aligned && cfg_idx == IDX_CHAR |=>
                                 rdata_o[CH_CLASS_LSB+3:CH_CLASS_LSB] == CHAR_CFG.dev_class)
    else $error("characteristics class wrong");

  // requests outside both windows belong to someone else and get no answer
  a_outside_quiet: assert property (take && !in_cfg && !in_rom |=> !ack_o && !rom_rd_o)
    else $error("answer outside the decoded windows");

  // a refusal is only ever shown together with its answer
  a_err_with_ack: assert property (err_o |-> ack_o)
    else $error("refusal without answer");

  // refused rom accesses answer at once, with zero data and no rom strobe
  a_rom_refuse: assert property (take && in_rom && (req_i.write || !rom_size_ok) |=>
                                 ack_o && err_o && rdata_o == 64'h0 && !rom_rd_o)
    else $error("refused rom access answered wrongly");

  // the strobe lasts one enabled cycle, so the rom sees each read once
  a_strobe_once: assert property (rom_rd_o && clk_en_i |=> !rom_rd_o)
    else $error("rom strobe stretched");

  // busy covers exactly the wait for rom data; the answer follows it
  a_busy_release: assert property (busy_o && clk_en_i |=> !busy_o && ack_o && !err_o)
    else $error("rom read not finished after busy");

  // with 4-byte spacing the rom word address is the window offset in words
  a_rom_addr: assert property (rom_good && CHAR_CFG.incr == INC_4 |=>
                               rom_addr_o == $past(rom_off[ROM_AW-1:DELTA_SHIFT_MIN]))
    else $error("rom word address wrong");

  // with 8-byte spacing the skip bit is squeezed out of the rom word address
  a_skip_addr: assert property (rom_good && CHAR_CFG.incr == INC_8 |=>
                                rom_addr_o == {1'b0, $past(rom_off[ROM_AW-1:SKIP_BIT+1])})
    else $error("rom word address keeps the skip bit");

  // a byte read returns its lane in the low byte and nothing above it
  a_byte_lane: assert property (rom_good && req_i.size == SZ_BYTE ##2 ack_o |-> rdata_o[63:8] == '0)
    else $error("byte rom read has stray bits");

  // region hits only follow a taken request and clear on the next enabled cycle that takes none
  a_hit_idle: assert property (clk_en_i && !take |=> mem_hit_o == 2'h0)
    else $error("stale region hit");

  // stored bases never hold bits that the region size leaves out
  a_base_clean: assert property ((base_reg[0] & ~mask1) == '0 && (base_reg[1] & ~mask2) == '0)
    else $error("base register holds dropped bits");

  c_cfg_write: cover property (take && in_cfg && req_i.write && is_unit);
  c_rom_word: cover property (rom_good && req_i.size == SZ_WORD ##2 ack_o);
  c_rom_refused: cover property (ack_o && err_o);
  c_mem_hit: cover property (mem_hit_o[0]);
  c_rom_skip: cover property (take && in_rom && rom_skip);
endmodule

/* File: core/cfg_space_pkg.sv */
// Purpose: shared constants and types for the configuration register slave
// Assumes: 64-bit system bus addresses, data bit 31 is the word's bit 0 (msb first numbering)
// Notes: field positions are given as lsb-numbered data bits
package cfg_space_pkg;
  // fixed address windows
  localparam logic [63:0] CFG_BASE = 64'hFFFF_FFFF_FF20_0000;
  localparam logic [63:0] CFG_SPAN = 64'h0000_0000_0000_0100;
  localparam logic [63:0] ROM_BASE = 64'hFFFF_FFFF_FFA0_0000;
  localparam logic [63:0] ROM_LAST = 64'hFFFF_FFFF_FFBF_FFFF;
  // register indices in units of the spacing
  localparam logic [4:0] IDX_CHAR = 5'h00;
  localparam logic [4:0] IDX_IDENT = 5'h01;
  localparam logic [4:0] IDX_UNIT_FIRST = 5'h02;
  localparam logic [4:0] IDX_BASE1 = 5'h06;
  localparam logic [4:0] IDX_BASE2_NARROW = 5'h07;
  localparam logic [4:0] IDX_BASE2_WIDE = 5'h08;
  // identity word layout
  localparam int ID_MAKER_BIT = 31;
  localparam int ID_RSVD_LSB = 24;
  localparam int ID_TYPE_LSB = 8;
  localparam logic [6:0] ID_RSVD_VALUE = 7'h00;
  // bus unit identifier field
  localparam int UNIT_LSB = 16;
  localparam int UNIT_W = 9;
  // memory base fields, 1 MB granularity
  localparam int BASE_LSB = 20;
  localparam int NARROW_BASE_W = 12;
  localparam int WIDE_BASE_W = 44;
  // characteristics word layout
  localparam int CH_CLASS_LSB = 28;
  localparam int CH_ALLOC_LSB = 26;
  localparam int CH_MEM1_LSB = 20;
  localparam int CH_MEM2_LSB = 16;
  localparam int CH_ROM_LSB = 5;
  localparam int CH_INC_LSB = 2;
  localparam logic [3:0] CLASS_IO = 4'h3;
  localparam logic [1:0] ROM_NONE = 2'h0;
  localparam logic [1:0] ROM_BYTE = 2'h2;
  localparam logic [1:0] ROM_WORD = 2'h3;
  localparam logic [2:0] INC_4 = 3'h0;
  localparam logic [2:0] INC_8 = 3'h1;
  localparam int DELTA_SHIFT_MIN = 2;
  // lsb-numbered address bit that is big-endian bit 29 of a word address
  localparam int SKIP_BIT = 2;
  localparam int ROM_AW = 21;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} acc_size_t;

  typedef struct packed {
    logic write;
    acc_size_t size;
    logic [63:0] addr;
    logic [63:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [3:0] dev_class;
    logic [1:0] unit_alloc;
    logic [3:0] mem1;
    logic [3:0] mem2;
    logic [1:0] rom_ind;
    logic [2:0] incr;
  } char_cfg_t;
endpackage

/* File: verification/rom_model.sv */
// Purpose: option rom that sits behind the device and answers its read strobe
// Assumes: the device looks at the data while its strobe stands
// Notes: between reads the data lines toggle, so a stale word never matches by luck
`timescale 1ns/1ps
module rom_model (
  input wire logic core_clk_i,        // bus clock
  input wire logic rom_rd_i,          // read strobe from the device
  input wire logic [18:0] rom_addr_i, // content word address
  output logic [31:0] rom_data_o      // content word
);
  logic [31:0] junk_reg = 32'h5A5A_5A5A;
  // content is a fixed function of the address with four distinct lanes
  assign rom_data_o = rom_rd_i ? {~rom_addr_i[7:0], rom_addr_i[7:0] ^ 8'h3C, rom_addr_i[15:8] ^ 8'h96,
                                  rom_addr_i[7:0]} : junk_reg;
  // idle pattern changes every cycle
  always @(posedge core_clk_i) begin
    junk_reg <= ~junk_reg;
  end
endmodule

/* File: verification/device_config_space_regs_tb.sv */
// Purpose: self-checking bench for the configuration register slave
// Assumes: instance 0 is narrow with a word rom, instance 1 wide with a byte rom and 8-byte spacing
// Notes: expected values come from a small register model kept in the bench
`timescale 1ns/1ps
module device_config_space_regs_tb;
  import cfg_space_pkg::*;
  localparam char_cfg_t CFG_A = '{dev_class: 4'h3, unit_alloc: 2'h3, mem1: 4'h1, mem2: 4'h2, rom_ind: 2'h3,
                                  incr: 3'h0};
  localparam char_cfg_t CFG_B = '{dev_class: 4'h3, unit_alloc: 2'h1, mem1: 4'h1, mem2: 4'h0, rom_ind: 2'h2,
                                  incr: 3'h1};
  logic core_clk_i, reset_i, clk_en_i, slot_en_i, req_valid_i;
  bus_req_t req_i;
  wire [1:0] ack, err, busy, rrd;
  wire [63:0] rdata [2];
  wire [18:0] raddr [2];
  wire [31:0] rdat [2];
  wire [1:0] mhit [2];
  int err_count = 0;
  int checked = 0;
  int rd_cnt [2] = '{0, 0};
  int bz_cnt [2] = '{0, 0};
  int n0;
  logic [18:0] last_addr [2];
  logic [31:0] unit_m [4];
  logic [63:0] r, v;
  logic [20:0] off;
  logic e, g;

  // two devices share the bus; each has its own rom behind it
  for (genvar k = 0; k < 2; k++) begin : dev
    device_config_space_regs #(.CHAR_CFG(k ? CFG_B : CFG_A), .WIDE_VARIANT(1'(k)), .DEFER_IDENTITY(1'(k))) uut (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .slot_en_i(slot_en_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .rom_data_i(rdat[k]), .busy_o(busy[k]), .ack_o(ack[k]),
      .err_o(err[k]), .rdata_o(rdata[k]), .mem_hit_o(mhit[k]), .rom_rd_o(rrd[k]), .rom_addr_o(raddr[k]));
    rom_model rom (.core_clk_i(core_clk_i), .rom_rd_i(rrd[k]), .rom_addr_i(raddr[k]), .rom_data_o(rdat[k]));
  end

  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // count rom strobes so refused or skipped reads can be seen to issue none
  always @(negedge core_clk_i) begin
    for (int k = 0; k < 2; k++) begin
      if (rrd[k] === 1'b1) begin
        rd_cnt[k]++;
        last_addr[k] = raddr[k];
      end
      if (busy[k] === 1'b1) begin
        bz_cnt[k]++;
      end
    end
  end

  function automatic logic [31:0] romw(input logic [18:0] a);
    return {~a[7:0], a[7:0] ^ 8'h3C, a[15:8] ^ 8'h96, a[7:0]};
  endfunction

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one request taken at the next edge, then a bounded wait for device s to answer
  task automatic acc(input int s, input logic w, input acc_size_t sz, input logic [63:0] a, input logic [63:0] d,
                     output logic [63:0] rd, output logic er, output logic got);
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{write: w, size: sz, addr: a, wdata: d};
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    got = 1'b0;
    rd = '0;
    er = 1'b0;
    for (int n = 0; n < 4 && !got; n++) begin
      @(negedge core_clk_i);
      if (ack[s] === 1'b1) begin
        got = 1'b1;
        rd = rdata[s];
        er = err[s];
      end
    end
  endtask

  task automatic creg(input int s, input logic w, input acc_size_t sz, input int o, input logic [63:0] d,
                      input logic [63:0] exp);
    acc(s, w, sz, CFG_BASE + 64'(o), d, r, e, g);
    check("cfg ack", {63'h0, g}, 64'h1);
    check("cfg data", r, exp);
  endtask

  task automatic rom(input int s, input logic w, input acc_size_t sz, input logic [20:0] o,
                     input logic [63:0] exp, input logic ee);
    acc(s, w, sz, ROM_BASE + {43'h0, o}, 64'hFFFF, r, e, g);
    check("rom ack", {63'h0, g}, 64'h1);
    check("rom err", {63'h0, e}, {63'h0, ee});
    check("rom data", r, exp);
  endtask

  // a memory-space request; the hit flags answer one edge after it is taken
  task automatic probe(input logic [63:0] a, input logic [1:0] exp);
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{write: 1'b0, size: SZ_WORD, addr: a, wdata: 64'h0};
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    @(negedge core_clk_i);
    check("mem hit", {62'h0, mhit[0]}, {62'h0, exp});
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  initial begin
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    slot_en_i = 1'b0;
    req_valid_i = 1'b0;
    req_i = '0;
    void'($urandom(39417));
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // fixed words, reset values, unmapped places
    creg(0, 0, SZ_WORD, 0, 0, 64'h3C12_0060);
    creg(0, 1, SZ_WORD, 4, 64'hFFFF_FFFF, 0);
    creg(0, 0, SZ_WORD, 4, 0, 64'h8000_405A);
    for (int k = 2; k < 10; k++) creg(0, 0, SZ_WORD, k * 4, 0, 0);
    // random identifiers keep only their field
    for (int k = 0; k < 4; k++) begin
      v = {32'h0, $urandom()};
      unit_m[k] = v[31:0] & 32'h01FF_0000;
      creg(0, 1, SZ_WORD, (k + 2) * 4, v, 0);
    end
    for (int k = 0; k < 4; k++) creg(0, 0, SZ_WORD, (k + 2) * 4, 0, {32'h0, unit_m[k]});
    // bases keep only the bits their region size needs
    v = {32'h0, $urandom()};
    creg(0, 1, SZ_WORD, 24, v, 0);
    creg(0, 0, SZ_WORD, 24, 0, v & 64'hFFF0_0000);
    creg(0, 1, SZ_WORD, 28, v, 0);
    creg(0, 0, SZ_WORD, 28, 0, v & 64'hFFE0_0000);
    creg(0, 1, SZ_WORD, 24, 64'h1230_0000, 0);
    creg(0, 1, SZ_WORD, 28, 64'h4560_0000, 0);
    probe(64'h1234_5678, 2'b01);
    probe(64'h4570_0010, 2'b10);
    probe(64'h4580_0000, 2'b00);
    // rom window is silent until the slot is enabled
    acc(0, 0, SZ_BYTE, ROM_BASE, 64'h0, r, e, g);
    check("slot off ack", {63'h0, g}, 64'h0);
    @(posedge core_clk_i);
    slot_en_i <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      off = 21'($urandom()) & 21'h1F_FFFC;
      rom(0, 0, SZ_WORD, off, {32'h0, romw(19'(off >> 2))}, 1'b0);
      check("rom addr", {45'h0, last_addr[0]}, {45'h0, 19'(off >> 2)});
    end
    for (int k = 0; k < 4; k++) rom(0, 0, SZ_BYTE, 21'(64 + k), 64'((romw(19'h10) >> (24 - 8 * k)) & 32'hFF), 1'b0);
    n0 = rd_cnt[0];
    rom(0, 1, SZ_BYTE, 8, 0, 1'b1);
    rom(0, 0, SZ_WORD, 2, 0, 1'b1);
    check("strobes", 64'(rd_cnt[0]), 64'(n0));
    // frozen clock enable takes nothing
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    acc(0, 0, SZ_WORD, CFG_BASE + 64'h4, 0, r, e, g);
    check("frozen ack", {63'h0, g}, 64'h0);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    // second device: 8-byte spacing, wide bases, byte rom, deferred identity
    creg(1, 0, SZ_WORD, 0, 0, 64'h3410_0044);
    creg(1, 0, SZ_WORD, 8, 0, 64'h8000_0000);
    creg(1, 1, SZ_WORD, 16, 64'hFFFF_FFFF, 0);
    creg(1, 0, SZ_WORD, 16, 0, 64'h01FF_0000);
    creg(1, 1, SZ_WORD, 24, 64'hFFFF_FFFF, 0);
    creg(1, 0, SZ_WORD, 24, 0, 0);
    v = {$urandom(), $urandom()};
    creg(1, 1, SZ_DWORD, 48, v, 0);
    creg(1, 0, SZ_DWORD, 48, 0, v & 64'hFFFF_FFFF_FFF0_0000);
    creg(1, 0, SZ_DWORD, 64, 0, 0);
    n0 = rd_cnt[1];
    rom(1, 0, SZ_BYTE, 4, 0, 1'b0);
    check("skip strobes", 64'(rd_cnt[1]), 64'(n0));
    rom(1, 0, SZ_BYTE, 42, 64'((romw(19'h5) >> 8) & 32'hFF), 1'b0);
    check("skip addr", {45'h0, last_addr[1]}, 64'h5);
    rom(1, 0, SZ_WORD, 8, 0, 1'b1);
    check("busy cycles", 64'(bz_cnt[0]), 64'(rd_cnt[0]));
    check("busy cycles", 64'(bz_cnt[1]), 64'(rd_cnt[1]));
    finish_test();
  end
endmodule
